// ==== design/bpc_port.v ====
// Operation
// - Eight-pin bidirectional port, each pin direction set by one direction bit.
// - Direction bit one tri-states the pin driver; pin is an input.
// - Direction bit zero drives the pin from its output latch.
// - Port read returns pin levels; port write updates the output latch.
// - Port writes are read-modify-write: sample pins, modify, store into latch.
// - Clearing option bit 7 enables weak pull-ups on all pins together.
// - Pull-up is forced off on any pin configured as output.
// - Pull-ups are disabled after power-on reset.
// - Only upper four pins, inputs only, take part in change detection.
// - Input pins compare against reference captured at last port read or write.
// - Mismatches are ORed to set change flag at interrupt control bit 0.
// - Asserted change interrupt can wake the device from sleep.
// - Any port read or write refreshes the reference, ending mismatch.
// - Persisting mismatch keeps setting the flag; software accesses port first.
// - A change coinciding with the port sample may miss the flag.
//
// Our own choice: the AXI4-Lite slave port.
`include "bpc_consts.vh"
module bpc_port #(
  parameter WIDTH = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out,
  output wire [WIDTH-1:0] pin_oe,
  output wire [WIDTH-1:0] pullup_en,
  input wire sleeping,
  output wire wake_req,
  output wire change_irq,
  output wire irq
);
  reg [WIDTH-1:0] pin_meta_r;
  reg [WIDTH-1:0] pin_sync_r;
  reg [WIDTH-1:0] latch_r;
  reg [WIDTH-1:0] dir_r;
  reg [7:0] option_r;
  reg [7:0] intctl_r;
  reg [WIDTH-1:0] ref_r;
  reg [1:0] status_r;
  reg [1:0] mask_r;
  reg [11:0] aw_addr_r;
  reg aw_have_r;
  reg [31:0] w_data_r;
  reg [3:0] w_strb_r;
  reg w_have_r;
  reg change_prev_r;
  wire do_write;
  wire do_read;
  wire port_wr;
  wire port_rd;
  wire [WIDTH-1:0] mismatch;
  wire change_any;
  wire flag_set;
  wire chg_flag;
  wire [WIDTH-1:0] port_rmw;

  // Pins are asynchronous to aclk
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta_r <= {WIDTH{1'b0}};
      pin_sync_r <= {WIDTH{1'b0}};
    end else begin
      pin_meta_r <= pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
      assign pin_oe[gi] = ~dir_r[gi];
      assign pin_out[gi] = latch_r[gi];
      assign pullup_en[gi] = ~option_r[`BPC_BIT_PULLUP_N] & dir_r[gi];
      if (gi >= `BPC_CHG_LO) begin : g_chg
        assign mismatch[gi] = dir_r[gi] & (pin_sync_r[gi] ^ ref_r[gi]);
      end else begin : g_nochg
        assign mismatch[gi] = 1'b0;
      end
    end
  endgenerate

  // Write side accepts address and data in either order
  assign s_axi_awready = ~aw_have_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_r & ~s_axi_bvalid;
  assign do_write = aw_have_r & w_have_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_read = s_axi_arvalid & s_axi_arready;
  assign port_wr = do_write & (aw_addr_r == `BPC_ADDR_PORT);
  assign port_rd = do_read & (s_axi_araddr == `BPC_ADDR_PORT);

  // Byte 0 merges over the sampled pins, not the latch
  assign port_rmw = w_strb_r[0] ? w_data_r[WIDTH-1:0] : pin_sync_r;

  assign change_any = |mismatch;
  // The reference is only refreshed at the end of a port access, so flag_set
  // is gated off during that access cycle to keep it from raising the flag
  assign flag_set = change_any & ~(port_rd | port_wr);
  assign chg_flag = intctl_r[`BPC_BIT_CHG_FLAG];
  assign change_irq = chg_flag & intctl_r[`BPC_BIT_CHG_EN];
  assign wake_req = sleeping & change_irq;
  assign irq = |(status_r & mask_r);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 12'h000;
      w_have_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BPC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr_r)
          `BPC_ADDR_PORT, `BPC_ADDR_OPTION, `BPC_ADDR_DIR, `BPC_ADDR_INTCTL,
          `BPC_ADDR_IRQ_STATUS, `BPC_ADDR_IRQ_MASK: s_axi_bresp <= `BPC_RESP_OKAY;
          default: s_axi_bresp <= `BPC_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register state
  always @(posedge aclk) begin
    if (!aresetn) begin
      latch_r <= {WIDTH{1'b0}};
      dir_r <= `BPC_DIR_RST;
      option_r <= `BPC_OPTION_RST;
      intctl_r <= `BPC_INTCTL_RST;
      ref_r <= {WIDTH{1'b0}};
      status_r <= 2'h0;
      mask_r <= `BPC_MASK_RST;
      change_prev_r <= 1'b0;
    end else begin
      change_prev_r <= change_irq;
      if (port_wr) begin
        latch_r <= port_rmw;
      end
      if (port_rd | port_wr) begin
        ref_r <= pin_sync_r;
      end
      if (do_write & w_strb_r[0]) begin
        case (aw_addr_r)
          `BPC_ADDR_OPTION: option_r <= w_data_r[7:0];
          `BPC_ADDR_DIR: dir_r <= w_data_r[WIDTH-1:0];
          `BPC_ADDR_IRQ_MASK: mask_r <= w_data_r[1:0];
          default: ;
        endcase
      end
      // Set wins over a software clear in the same cycle
      if (do_write & w_strb_r[0] & (aw_addr_r == `BPC_ADDR_INTCTL)) begin
        intctl_r <= {w_data_r[7:1], w_data_r[0] | flag_set};
      end else if (flag_set) begin
        intctl_r[`BPC_BIT_CHG_FLAG] <= 1'b1;
      end
      // Status bit 0: change interrupt rose; bit 1: port mismatch seen
      if (do_write & w_strb_r[0] & (aw_addr_r == `BPC_ADDR_IRQ_STATUS)) begin
        status_r <= (status_r & ~w_data_r[1:0]) | {flag_set, change_irq & ~change_prev_r};
      end else begin
        status_r <= status_r | {flag_set, change_irq & ~change_prev_r};
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `BPC_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `BPC_RESP_OKAY;
      case (s_axi_araddr)
        `BPC_ADDR_PORT: s_axi_rdata <= {{(32-WIDTH){1'b0}}, pin_sync_r};
        `BPC_ADDR_OPTION: s_axi_rdata <= {24'h000000, option_r};
        `BPC_ADDR_DIR: s_axi_rdata <= {{(32-WIDTH){1'b0}}, dir_r};
        `BPC_ADDR_INTCTL: s_axi_rdata <= {24'h000000, intctl_r};
        `BPC_ADDR_IRQ_STATUS: s_axi_rdata <= {30'h00000000, status_r};
        `BPC_ADDR_IRQ_MASK: s_axi_rdata <= {30'h00000000, mask_r};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `BPC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== design/bpc_consts.vh ====
`ifndef BPC_CONSTS_VH
`define BPC_CONSTS_VH
// Register indices; byte address is four times the index
`define BPC_IDX_PORT 8'h06
`define BPC_IDX_OPTION 8'h81
`define BPC_IDX_DIR 8'h86
`define BPC_IDX_INTCTL 8'h8B
`define BPC_IDX_IRQ_STATUS 8'hC0
`define BPC_IDX_IRQ_MASK 8'hC1
`define BPC_ADDR_PORT 12'h018
`define BPC_ADDR_OPTION 12'h204
`define BPC_ADDR_DIR 12'h218
`define BPC_ADDR_INTCTL 12'h22C
`define BPC_ADDR_IRQ_STATUS 12'h300
`define BPC_ADDR_IRQ_MASK 12'h304
`define BPC_OPTION_RST 8'hFF
`define BPC_DIR_RST 8'hFF
`define BPC_INTCTL_RST 8'h00
`define BPC_MASK_RST 2'h0
`define BPC_BIT_PULLUP_N 7
`define BPC_BIT_CHG_FLAG 0
`define BPC_BIT_CHG_EN 3
`define BPC_CHG_LO 4
`define BPC_RESP_OKAY 2'h0
`define BPC_RESP_SLVERR 2'h2
`endif

// ==== sim/bpc_properties.sv ====
module bpc_properties (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire [7:0] pin_oe,
  input wire [7:0] pullup_en,
  input wire sleeping,
  input wire wake_req,
  input wire change_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_once; s_axi_rvalid ##1 !s_axi_rvalid; endsequence
  property p_rans; s_ar |=> s_once; endproperty
  a_rans: assert property (p_rans) else $error("read answer wrong");
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write answer stuck");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_arr; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_arr: assert property (p_arr) else $error("read taken while busy");
  property p_awr; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_awr: assert property (p_awr) else $error("write taken while busy");
  property p_pu; (pullup_en & pin_oe) == 8'h00; endproperty
  a_pu: assert property (p_pu) else $error("pull-up on driven pin");
  property p_rst; $rose(aresetn) |-> pin_oe == 8'h00 && pullup_en == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("pins not idle after reset");
  property p_wake; wake_req == (sleeping && change_irq); endproperty
  a_wake: assert property (p_wake) else $error("wake request wrong");
endmodule

// ==== sim/bpc_keypad.sv ====
module bpc_keypad (
  input wire aclk,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  input wire [7:0] pullup_en,
  input wire [7:0] key,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wig = 8'h55;
  // Floating pins wander so a stale level never passes
  always @(posedge aclk) wig <= ~wig;
  always_comb for (int i = 0; i < 8; i++)
    pin_in[i] = pin_oe[i] ? pin_out[i] : key[i] ? 1'b0 : pullup_en[i] ? 1'b1 : wig[i];
endmodule

// ==== sim/bidir_port_with_change_irq_bench.sv ====
`include "bpc_consts.vh"
module bidir_port_with_change_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, sleeping = 0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [7:0] key = '0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0] pin_in, pin_out, pin_oe, pullup_en;
  wire wake_req, change_irq, irq;
  int error_cnt = 0, compares = 0, cyc = 0;
  bpc_port uut (.*);
  bpc_keypad partner (.*);
  initial forever #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    // Whole run needs under 1000 cycles
    if (cyc == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] exp, input [1:0] rsp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, rsp);
  endtask
  task t_reset;
    rd(`BPC_ADDR_OPTION, 32'h000000FF, `BPC_RESP_OKAY);
    rd(`BPC_ADDR_DIR, 32'h000000FF, `BPC_RESP_OKAY);
    rd(12'hFFC, 32'h00000000, `BPC_RESP_SLVERR);
    chk(pullup_en, 8'h00);
    wr(12'hFFC, 8'h00);
    chk(s_axi_bresp, `BPC_RESP_SLVERR);
  endtask
  task t_pull;
    // Flat address map stands in for the bank switch
    wr(`BPC_ADDR_OPTION, 8'h7F);
    chk(s_axi_bresp, `BPC_RESP_OKAY);
    chk(pullup_en, 8'hFF);
    wr(`BPC_ADDR_DIR, 8'hF0);
    chk(pin_oe, 8'h0F);
    chk(pullup_en, 8'hF0);
    wr(`BPC_ADDR_PORT, 8'h05);
    chk(pin_out, 8'h05);
    repeat (4) @(posedge aclk);
    rd(`BPC_ADDR_PORT, 32'h000000F5, `BPC_RESP_OKAY);
  endtask
  task t_change;
    wr(`BPC_ADDR_INTCTL, 8'h08);
    sleeping <= 1;
    key <= 8'h11;
    // Wait rather than poll the port, which would refresh the reference
    repeat (5) @(posedge aclk);
    chk({change_irq, wake_req, irq}, 3'h6);
    rd(`BPC_ADDR_INTCTL, 32'h00000009, `BPC_RESP_OKAY);
    wr(`BPC_ADDR_IRQ_MASK, 8'h01);
    chk(irq, 1'b1);
    wr(`BPC_ADDR_INTCTL, 8'h08);
    rd(`BPC_ADDR_INTCTL, 32'h00000009, `BPC_RESP_OKAY);
    rd(`BPC_ADDR_PORT, 32'h000000E5, `BPC_RESP_OKAY);
    wr(`BPC_ADDR_INTCTL, 8'h08);
    rd(`BPC_ADDR_INTCTL, 32'h00000008, `BPC_RESP_OKAY);
    wr(`BPC_ADDR_IRQ_STATUS, 8'h03);
    chk({change_irq, irq}, 2'h0);
  endtask
  task end_of_test;
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset();
    t_pull();
    t_change();
    end_of_test();
  end
endmodule
bind bpc_port bpc_properties chk (.*);
